// *** rtl/sfc_codec.sv ***
// Purpose: Framer and deframer for the host serial byte stream
// Assumes: Byte strobes already out of a UART; inputs synchronous to clk_in
// Notes:   Bad frames vanish silently; escaping applies both ways in mode 2
`timescale 1ns/100ps

module sfc_codec #(
   parameter int RX_DEPTH = sfc_pkg::RX_BUF_DEPTH,
   parameter int TX_DEPTH = sfc_pkg::TX_BUF_DEPTH
) (
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic [1:0] interface_mode_select_in,
   input  wire logic [7:0] serial_data_input_in,
   input  wire logic       serial_data_input_valid_in,
   output logic [7:0]      radio_data_out,
   output logic            radio_valid_out,
   output logic            radio_frame_last_out,
   input  wire logic       radio_ready_in,
   input  wire logic [7:0] radio_rx_data_in,
   input  wire logic       radio_rx_valid_in,
   input  wire logic       radio_rx_last_in,
   output logic            radio_rx_ready_out,
   input  wire logic [7:0] status_code_in,
   input  wire logic       status_event_in,
   output logic            status_busy_out,
   output logic [7:0]      serial_data_out,
   output logic            serial_data_valid_out,
   input  wire logic       serial_ready_in
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic needs_escape(input logic [7:0] b);
      return (b == sfc_pkg::DELIM) || (b == sfc_pkg::ESC) ||
             (b == sfc_pkg::XON) || (b == sfc_pkg::XOFF);
   endfunction

   logic transparent;
   logic escaped;
   assign transparent = (interface_mode_select_in == sfc_pkg::MODE_TRANSPARENT);
   assign escaped     = (interface_mode_select_in == sfc_pkg::MODE_ESCAPED);

   // ***************************************************************
   // Receive side: host to radio
   // ***************************************************************
   sfc_pkg::sfc_rx_e rx_state_reg;
   logic [7:0]       rx_buf [RX_DEPTH];
   logic [15:0]      rx_len_reg;
   logic [15:0]      rx_cnt_reg;
   logic [7:0]       rx_sum_reg;
   logic             rx_esc_reg;
   logic [15:0]      rx_rd_reg;
   logic [7:0]       rx_byte;
   logic             rx_take;
   logic             rx_out_hold;

   assign rx_out_hold = (rx_state_reg == sfc_pkg::SFC_RX_OUT);
   // Raw escape prefix is consumed; the next byte is unmasked
   assign rx_byte = rx_esc_reg ? (serial_data_input_in ^ sfc_pkg::ESC_MASK)
                               : serial_data_input_in;
   assign rx_take = serial_data_input_valid_in && !transparent && !rx_out_hold &&
                    !(escaped && serial_data_input_in == sfc_pkg::ESC && !rx_esc_reg);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_esc_reg <= 1'b0;
      end else if (transparent || !escaped || rx_out_hold) begin
         rx_esc_reg <= 1'b0;
      end else if (serial_data_input_valid_in) begin
         rx_esc_reg <= (serial_data_input_in == sfc_pkg::ESC) && !rx_esc_reg;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
         rx_len_reg   <= 16'h0000;
         rx_cnt_reg   <= 16'h0000;
         rx_sum_reg   <= 8'h00;
         rx_rd_reg    <= 16'h0000;
      end else if (transparent) begin
         rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
      end else if (rx_out_hold) begin
         if (radio_ready_in) begin
            if (rx_rd_reg + 16'h0001 == rx_len_reg) begin
               rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
            end
            rx_rd_reg <= rx_rd_reg + 16'h0001;
         end
      end else if (rx_take && escaped && !rx_esc_reg &&
                   serial_data_input_in == sfc_pkg::DELIM) begin
         rx_state_reg <= sfc_pkg::SFC_RX_LENH;
      end else if (rx_take) begin
         unique case (rx_state_reg)
            sfc_pkg::SFC_RX_HUNT: begin
               if (serial_data_input_in == sfc_pkg::DELIM) begin
                  rx_state_reg <= sfc_pkg::SFC_RX_LENH;
               end
            end
            sfc_pkg::SFC_RX_LENH: begin
               rx_len_reg[15:8] <= rx_byte;
               rx_state_reg     <= sfc_pkg::SFC_RX_LENL;
            end
            sfc_pkg::SFC_RX_LENL: begin
               rx_len_reg[7:0] <= rx_byte;
               rx_cnt_reg      <= 16'h0000;
               rx_sum_reg      <= 8'h00;
               if ({rx_len_reg[15:8], rx_byte} == 16'h0000 ||
                   {rx_len_reg[15:8], rx_byte} > 16'(RX_DEPTH)) begin
                  rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
               end else begin
                  rx_state_reg <= sfc_pkg::SFC_RX_DATA;
               end
            end
            sfc_pkg::SFC_RX_DATA: begin
               rx_sum_reg <= rx_sum_reg + rx_byte;
               rx_cnt_reg <= rx_cnt_reg + 16'h0001;
               if (rx_cnt_reg + 16'h0001 == rx_len_reg) begin
                  rx_state_reg <= sfc_pkg::SFC_RX_SUM;
               end
            end
            sfc_pkg::SFC_RX_SUM: begin
               rx_rd_reg <= 16'h0000;
               if (8'(rx_sum_reg + rx_byte) == sfc_pkg::SUM_GOOD) begin
                  rx_state_reg <= sfc_pkg::SFC_RX_OUT;
               end else begin
                  rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
               end
            end
            default: rx_state_reg <= sfc_pkg::SFC_RX_HUNT;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rx_take && rx_state_reg == sfc_pkg::SFC_RX_DATA) begin
         rx_buf[rx_cnt_reg[$clog2(RX_DEPTH)-1:0]] <= rx_byte;
      end
   end

   // Checked frame data (type id first) or raw bytes go to the radio
   always_comb begin
      if (transparent) begin
         radio_data_out       = serial_data_input_in;
         radio_valid_out      = serial_data_input_valid_in;
         radio_frame_last_out = 1'b0;
      end else begin
         radio_data_out       = rx_buf[rx_rd_reg[$clog2(RX_DEPTH)-1:0]];
         radio_valid_out      = rx_out_hold;
         radio_frame_last_out = rx_out_hold && (rx_rd_reg + 16'h0001 == rx_len_reg);
      end
   end

   // ***************************************************************
   // Transmit side: radio and status to host
   // ***************************************************************
   sfc_pkg::sfc_tx_e tx_state_reg;
   logic [7:0]       tx_buf [TX_DEPTH];
   logic [15:0]      tx_len_reg;
   logic [15:0]      tx_rd_reg;
   logic [7:0]       tx_sum_reg;
   logic             tx_fill_reg;
   logic             tx_esc_pend_reg;
   logic [7:0]       tx_raw;
   logic             tx_step;
   logic             status_pend_reg;
   logic [7:0]       status_code_reg;

   assign radio_rx_ready_out = transparent ? serial_ready_in
                                           : (tx_state_reg == sfc_pkg::SFC_TX_IDLE);
   assign status_busy_out    = status_pend_reg;
   assign tx_step = serial_ready_in && tx_state_reg != sfc_pkg::SFC_TX_IDLE && !transparent;

   always_comb begin
      unique case (tx_state_reg)
         sfc_pkg::SFC_TX_LENH: tx_raw = tx_len_reg[15:8];
         sfc_pkg::SFC_TX_LENL: tx_raw = tx_len_reg[7:0];
         sfc_pkg::SFC_TX_DATA: tx_raw = tx_buf[tx_rd_reg[$clog2(TX_DEPTH)-1:0]];
         sfc_pkg::SFC_TX_SUM:  tx_raw = sfc_pkg::SUM_GOOD - tx_sum_reg;
         default:              tx_raw = sfc_pkg::DELIM;
      endcase
   end

   // Status event is remembered until transmit is idle with no radio byte offered; a half-filled radio frame drops it
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_pend_reg <= 1'b0;
         status_code_reg <= 8'h00;
      end else if (status_event_in && !transparent) begin
         status_pend_reg <= 1'b1;
         status_code_reg <= status_code_in;
      end else if (tx_state_reg == sfc_pkg::SFC_TX_IDLE && !radio_rx_valid_in) begin
         status_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (tx_state_reg == sfc_pkg::SFC_TX_IDLE && !transparent) begin
         if (radio_rx_valid_in) begin
            tx_buf[tx_len_reg[$clog2(TX_DEPTH)-1:0]] <= radio_rx_data_in;
         end else if (status_pend_reg) begin
            tx_buf[0] <= sfc_pkg::STATUS_TYPE_ID;
            tx_buf[1] <= status_code_reg;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_state_reg    <= sfc_pkg::SFC_TX_IDLE;
         tx_len_reg      <= 16'h0000;
         tx_rd_reg       <= 16'h0000;
         tx_sum_reg      <= 8'h00;
         tx_fill_reg     <= 1'b0;
         tx_esc_pend_reg <= 1'b0;
      end else if (transparent) begin
         tx_state_reg    <= sfc_pkg::SFC_TX_IDLE;
         tx_len_reg      <= 16'h0000;
         tx_fill_reg     <= 1'b0;
         tx_esc_pend_reg <= 1'b0;
      end else if (tx_state_reg == sfc_pkg::SFC_TX_IDLE) begin
         tx_rd_reg  <= 16'h0000;
         tx_sum_reg <= 8'h00;
         if (radio_rx_valid_in) begin
            tx_fill_reg <= 1'b1;
            tx_len_reg  <= tx_len_reg + 16'h0001;
            if (radio_rx_last_in ||
                tx_len_reg + 16'h0001 == 16'(TX_DEPTH)) begin
               tx_state_reg <= sfc_pkg::SFC_TX_DLM;
            end
         end else if (status_pend_reg && !tx_fill_reg) begin
            tx_len_reg   <= 16'h0002;
            tx_state_reg <= sfc_pkg::SFC_TX_DLM;
         end
      end else if (tx_step) begin
         if (escaped && !tx_esc_pend_reg && tx_state_reg != sfc_pkg::SFC_TX_DLM &&
             needs_escape(tx_raw)) begin
            tx_esc_pend_reg <= 1'b1;
         end else begin
            tx_esc_pend_reg <= 1'b0;
            unique case (tx_state_reg)
               sfc_pkg::SFC_TX_DLM:  tx_state_reg <= sfc_pkg::SFC_TX_LENH;
               sfc_pkg::SFC_TX_LENH: tx_state_reg <= sfc_pkg::SFC_TX_LENL;
               sfc_pkg::SFC_TX_LENL: tx_state_reg <= sfc_pkg::SFC_TX_DATA;
               sfc_pkg::SFC_TX_DATA: begin
                  tx_sum_reg <= tx_sum_reg + tx_raw;
                  tx_rd_reg  <= tx_rd_reg + 16'h0001;
                  if (tx_rd_reg + 16'h0001 == tx_len_reg) begin
                     tx_state_reg <= sfc_pkg::SFC_TX_SUM;
                  end
               end
               default: begin
                  tx_state_reg <= sfc_pkg::SFC_TX_IDLE;
                  tx_len_reg   <= 16'h0000;
                  tx_fill_reg  <= 1'b0;
               end
            endcase
         end
      end
   end

   always_comb begin
      if (transparent) begin
         serial_data_out       = radio_rx_data_in;
         serial_data_valid_out = radio_rx_valid_in;
      end else begin
         serial_data_valid_out = tx_state_reg != sfc_pkg::SFC_TX_IDLE;
         if (escaped && tx_state_reg != sfc_pkg::SFC_TX_DLM && needs_escape(tx_raw)) begin
            serial_data_out = tx_esc_pend_reg ? (tx_raw ^ sfc_pkg::ESC_MASK)
                                              : sfc_pkg::ESC;
         end else begin
            serial_data_out = tx_raw;
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_bad_sum_drop;
      @(posedge clk_in) disable iff (!rst_b_in)
      (rx_take && rx_state_reg == sfc_pkg::SFC_RX_SUM &&
       !(escaped && !rx_esc_reg && serial_data_input_in == sfc_pkg::DELIM) &&
       8'(rx_sum_reg + rx_byte) != sfc_pkg::SUM_GOOD && !transparent)
      |=> rx_state_reg == sfc_pkg::SFC_RX_HUNT && !radio_valid_out;
   endproperty
   a_bad_sum_drop: assert property (p_bad_sum_drop)
      else $error("bad checksum frame not dropped");

   property p_hunt_ignores;
      @(posedge clk_in) disable iff (!rst_b_in)
      (!transparent && rx_state_reg == sfc_pkg::SFC_RX_HUNT && rx_take &&
       serial_data_input_in != sfc_pkg::DELIM)
      |=> rx_state_reg == sfc_pkg::SFC_RX_HUNT;
   endproperty
   a_hunt_ignores: assert property (p_hunt_ignores)
      else $error("byte before delimiter not ignored");

   property p_tx_escape;
      @(posedge clk_in) disable iff (!rst_b_in)
      (escaped && tx_step && !tx_esc_pend_reg && tx_state_reg != sfc_pkg::SFC_TX_DLM &&
       needs_escape(tx_raw))
      |-> serial_data_out == sfc_pkg::ESC ##1 (serial_data_out == ($past(tx_raw) ^ 8'h20));
   endproperty
   a_tx_escape: assert property (p_tx_escape)
      else $error("escaped byte pair wrong");

   property p_tx_sum;
      @(posedge clk_in) disable iff (!rst_b_in)
      (tx_state_reg == sfc_pkg::SFC_TX_SUM && !transparent)
      |-> 8'(tx_raw + tx_sum_reg) == 8'hFF;
   endproperty
   a_tx_sum: assert property (p_tx_sum)
      else $error("transmit checksum wrong");

   property p_oversize;
      @(posedge clk_in) disable iff (!rst_b_in)
      (rx_take && rx_state_reg == sfc_pkg::SFC_RX_LENL && !transparent &&
       !(escaped && !rx_esc_reg && serial_data_input_in == sfc_pkg::DELIM) &&
       {rx_len_reg[15:8], rx_byte} > 16'(RX_DEPTH))
      |=> rx_state_reg == sfc_pkg::SFC_RX_HUNT;
   endproperty
   a_oversize: assert property (p_oversize)
      else $error("oversize frame not dropped");

   property p_restart;
      @(posedge clk_in) disable iff (!rst_b_in)
      (rx_take && escaped && !rx_esc_reg && serial_data_input_in == sfc_pkg::DELIM)
      |=> rx_state_reg == sfc_pkg::SFC_RX_LENH;
   endproperty
   a_restart: assert property (p_restart)
      else $error("raw delimiter did not restart frame");

   property p_transparent;
      @(posedge clk_in) disable iff (!rst_b_in)
      transparent |-> radio_valid_out == serial_data_input_valid_in &&
                      serial_data_valid_out == radio_rx_valid_in;
   endproperty
   a_transparent: assert property (p_transparent)
      else $error("transparent path altered");

   property p_frame_start;
      @(posedge clk_in) disable iff (!rst_b_in)
      (tx_state_reg == sfc_pkg::SFC_TX_DLM && !transparent)
      |-> serial_data_out == 8'h7E;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("frame does not start with delimiter");
endmodule

// *** rtl/sfc_pkg.sv ***
// Purpose: Constants for the serial frame codec
// Assumes: Byte-wide streams on one clock
// Notes:   Frame = delimiter, length high, length low, data, checksum
package sfc_pkg;
   localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
   localparam logic [1:0] MODE_FRAMED      = 2'h1;
   localparam logic [1:0] MODE_ESCAPED     = 2'h2;
   localparam logic [7:0] DELIM            = 8'h7E;
   localparam logic [7:0] ESC              = 8'h7D;
   localparam logic [7:0] ESC_MASK         = 8'h20;
   localparam logic [7:0] XON              = 8'h11;
   localparam logic [7:0] XOFF             = 8'h13;
   localparam logic [7:0] SUM_GOOD         = 8'hFF;
   localparam logic [7:0] STATUS_TYPE_ID   = 8'h8A;
   localparam int         RX_BUF_DEPTH     = 128;
   localparam int         TX_BUF_DEPTH     = 128;

   typedef enum logic [2:0] {
      SFC_RX_HUNT = 3'b000,
      SFC_RX_LENH = 3'b001,
      SFC_RX_LENL = 3'b011,
      SFC_RX_DATA = 3'b010,
      SFC_RX_SUM  = 3'b110,
      SFC_RX_OUT  = 3'b111
   } sfc_rx_e;

   typedef enum logic [2:0] {
      SFC_TX_IDLE = 3'b000,
      SFC_TX_DLM  = 3'b001,
      SFC_TX_LENH = 3'b011,
      SFC_TX_LENL = 3'b010,
      SFC_TX_DATA = 3'b110,
      SFC_TX_SUM  = 3'b111
   } sfc_tx_e;
endpackage

// *** tb/sfc_host_model.sv ***
// Purpose: Host controller model on the serial byte port of the codec
// Assumes: One byte per valid pulse toward the codec, bytes taken on valid and ready
// Notes:   Ready stalls three cycles in four while slow_in is high
`timescale 1ns/100ps
module sfc_host_model (
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   output logic [7:0]      tx_byte_out,
   output logic            tx_valid_out,
   input  wire logic [7:0] rx_byte_in,
   input  wire logic       rx_valid_in,
   output logic            rx_ready_out
);
   logic [7:0] rx_q[$];
   logic [1:0] stall_cnt = 2'h0;

   initial begin
      tx_byte_out = 8'h00;
      tx_valid_out = 1'b0;
      rx_ready_out = 1'b1;
   end

   // ***********************
   // Byte sender
   // ***********************
   // Payload only, never configuration traffic on this port
   task automatic send(input logic [7:0] b);
      @(posedge clk_in);
      tx_byte_out <= b;
      tx_valid_out <= 1'b1;
      @(posedge clk_in);
      tx_valid_out <= 1'b0;
      tx_byte_out <= ~b;
   endtask

   // ***********************
   // Byte receiver
   // ***********************
   always @(posedge clk_in) begin
      if (rx_valid_in && rx_ready_out) begin
         rx_q.push_back(rx_byte_in);
      end
      stall_cnt <= stall_cnt + 2'h1;
      rx_ready_out <= !slow_in || (stall_cnt == 2'h3);
   end
endmodule

// *** tb/serial_api_frame_codec_tb_top.sv ***
// Purpose: Self-checking bench for the serial frame codec
// Assumes: Receive depth shortened to 8 bytes
// Notes:   Radio ready toggles every cycle to stall the frame output
`timescale 1ns/100ps
module serial_api_frame_codec_tb_top;
   logic       clk_in = 1'b0;
   logic       rst_b_in;
   logic [1:0] mode;
   logic       radio_ready;
   logic       rrx_valid;
   logic       rrx_last;
   logic       status_event;
   logic       slow;
   logic [7:0] rrx_data;
   logic [7:0] status_code;
   logic [7:0] s_in, radio_data, ser_data;
   logic       s_in_valid, radio_valid, radio_last, rrx_ready, busy, ser_valid, ser_ready;
   logic [7:0] wq[$];
   logic [8:0] rq[$];
   int         fail_count = 0;
   int         checked = 0;

   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) radio_ready <= ~radio_ready;
   always @(posedge clk_in) begin
      if (rst_b_in && mode != 2'h0 && radio_valid && radio_ready) begin
         rq.push_back({radio_last, radio_data});
      end
   end

   sfc_codec #(.RX_DEPTH(8)) i_dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .interface_mode_select_in(mode),
      .serial_data_input_in(s_in), .serial_data_input_valid_in(s_in_valid),
      .radio_data_out(radio_data), .radio_valid_out(radio_valid),
      .radio_frame_last_out(radio_last), .radio_ready_in(radio_ready),
      .radio_rx_data_in(rrx_data), .radio_rx_valid_in(rrx_valid),
      .radio_rx_last_in(rrx_last), .radio_rx_ready_out(rrx_ready),
      .status_code_in(status_code), .status_event_in(status_event),
      .status_busy_out(busy), .serial_data_out(ser_data),
      .serial_data_valid_out(ser_valid), .serial_ready_in(ser_ready)
   );

   sfc_host_model i_host (
      .clk_in(clk_in), .slow_in(slow), .tx_byte_out(s_in), .tx_valid_out(s_in_valid),
      .rx_byte_in(ser_data), .rx_valid_in(ser_valid), .rx_ready_out(ser_ready)
   );

   // ***********************
   // Shared helpers
   // ***********************
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic void put(logic [7:0] b, bit esc);
      if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
         wq.push_back(8'h7D);
         wq.push_back(b ^ 8'h20);
      end else begin
         wq.push_back(b);
      end
   endfunction

   // Wire image of a frame; bad flips checksum bits
   function automatic void build(logic [7:0] d[$], bit esc, logic [7:0] bad);
      logic [7:0] s;
      s = 8'h00;
      wq.delete();
      wq.push_back(8'h7E);
      put(8'(d.size() >> 8), esc);
      put(8'(d.size()), esc);
      foreach (d[i]) begin
         put(d[i], esc);
         s = s + d[i];
      end
      put((8'hFF - s) ^ bad, esc);
   endfunction

   task automatic host_tx(logic [7:0] d[$], bit esc, logic [7:0] bad);
      build(d, esc, bad);
      foreach (wq[i]) i_host.send(wq[i]);
   endtask

   task automatic expect_radio(logic [7:0] d[$]);
      for (int n = 0; n < 400 && rq.size() < d.size(); n++) @(posedge clk_in);
      repeat (20) @(posedge clk_in);
      chk("radio_count", 8'(rq.size()), 8'(d.size()));
      foreach (d[i]) if (i < rq.size()) begin
         chk("radio_byte", rq[i][7:0], d[i]);
         chk("radio_last", {7'h0, rq[i][8]}, {7'h0, i == d.size() - 1});
      end
      rq.delete();
   endtask

   task automatic expect_host(logic [7:0] d[$], bit esc);
      build(d, esc, 8'h00);
      for (int n = 0; n < 400 && i_host.rx_q.size() < wq.size(); n++) @(posedge clk_in);
      repeat (20) @(posedge clk_in);
      chk("host_count", 8'(i_host.rx_q.size()), 8'(wq.size()));
      foreach (wq[i]) if (i < i_host.rx_q.size()) chk("host_byte", i_host.rx_q[i], wq[i]);
      i_host.rx_q.delete();
   endtask

   task automatic radio_send(logic [7:0] d[$]);
      logic r;
      foreach (d[i]) begin
         rrx_data <= d[i];
         rrx_valid <= 1'b1;
         rrx_last <= (i == d.size() - 1);
         r = 1'b0;
         for (int n = 0; n < 400 && !r; n++) begin
            @(negedge clk_in);
            r = rrx_ready;
            @(posedge clk_in);
         end
      end
      rrx_valid <= 1'b0;
      rrx_data <= ~rrx_data;
   endtask

   // ***********************
   // Scenarios
   // ***********************
   task automatic t_transparent();
      @(posedge clk_in);
      mode <= 2'h0;
      rrx_data <= 8'hC3;
      rrx_valid <= 1'b1;
      fork
         i_host.send(8'h5A);
         begin
            @(posedge clk_in);
            #1;
            chk("radio_data", radio_data, 8'h5A);
            chk("radio_valid", {7'h0, radio_valid}, 8'h01);
            chk("ser_data", ser_data, 8'hC3);
            chk("ser_valid", {7'h0, ser_valid}, 8'h01);
         end
      join
      rrx_valid <= 1'b0;
      repeat (2) @(posedge clk_in);
      i_host.rx_q.delete();
      $display("test transparent finished");
   endtask

   task automatic t_framed_rx();
      @(posedge clk_in);
      mode <= 2'h1;
      i_host.send(8'h55);
      i_host.send(8'h23);
      host_tx('{8'h23, 8'h11}, 1'b0, 8'h00);
      expect_radio('{8'h23, 8'h11});
      host_tx('{8'h08, 8'h7E, 8'h00}, 1'b0, 8'h00);
      expect_radio('{8'h08, 8'h7E, 8'h00});
      $display("test framed receive finished");
   endtask

   task automatic t_drop();
      host_tx('{8'h23, 8'h11}, 1'b0, 8'h01);
      host_tx('{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01}, 1'b0, 8'h00);
      host_tx('{8'h09, 8'h42}, 1'b0, 8'h00);
      expect_radio('{8'h09, 8'h42});
      $display("test drop finished");
   endtask

   task automatic t_escaped_rx();
      @(posedge clk_in);
      mode <= 2'h2;
      i_host.send(8'h7E);
      i_host.send(8'h00);
      i_host.send(8'h04);
      i_host.send(8'h23);
      host_tx('{8'h23, 8'h11}, 1'b1, 8'h00);
      expect_radio('{8'h23, 8'h11});
      host_tx('{8'h7E, 8'h7D, 8'h13}, 1'b1, 8'h00);
      expect_radio('{8'h7E, 8'h7D, 8'h13});
      $display("test escaped receive finished");
   endtask

   task automatic t_status();
      for (int e = 0; e < 2; e++) begin
         @(posedge clk_in);
         mode <= e[0] ? 2'h2 : 2'h1;
         slow <= 1'b1;
         status_code <= 8'h11;
         status_event <= 1'b1;
         @(posedge clk_in);
         status_event <= 1'b0;
         #1;
         chk("status_busy", {7'h0, busy}, 8'h01);
         expect_host('{8'h8A, 8'h11}, e[0]);
      end
      $display("test status finished");
   endtask

   task automatic t_radio_tx();
      for (int e = 0; e < 2; e++) begin
         @(posedge clk_in);
         mode <= e[0] ? 2'h2 : 2'h1;
         @(posedge clk_in);
         radio_send('{8'h7E, 8'h01, 8'h13});
         expect_host('{8'h7E, 8'h01, 8'h13}, e[0]);
      end
      $display("test radio transmit finished");
   endtask

   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk_in);
      fail_count++;
      end_of_test();
   end

   initial begin
      rst_b_in <= 1'b0;
      mode <= 2'h0;
      radio_ready <= 1'b0;
      rrx_valid <= 1'b0;
      rrx_last <= 1'b0;
      status_event <= 1'b0;
      slow <= 1'b0;
      rrx_data <= 8'h00;
      status_code <= 8'h00;
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_transparent();
      t_framed_rx();
      t_drop();
      t_escaped_rx();
      t_status();
      t_radio_tx();
      end_of_test();
   end
endmodule
